// >>> hw/cmh_top.v
// CAN mode handshake, protected configuration and time-quantum generator
//
// Function
// - Sleep ack reads 0 when running and 1 once sleep is really entered.
// - Sleep is active only while sleep request and sleep ack are both 1.
// - While asleep with wakeup enabled, bus activity clears sleep ack.
// - Init ack reads 0 when running and 1 once init mode is entered.
// - Init mode is active only while init request and init ack are both 1.
// - Bus timing 0 sits at offset 0x0002, reads anytime and resets to zero.
// - Bus timing 0 writes take effect only while init request and ack are both 1.
// - Bits 7-6 of bus timing 0 set the resynchronization jump width.
// - Jump width codes 00..11 mean one to four time quanta.
// - Bits 5-0 of bus timing 0 hold the time-quantum prescaler.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cmh_consts.vh"
module cmh_top #(
  parameter ADDR_W = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire can_rx,
  output reg tq_tick,
  output reg [2:0] sjw_tq,
  output reg init_mode,
  output reg sleep_mode
);

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  localparam ST_RUN = 2'd0;
  localparam ST_INIT = 2'd1;
  localparam ST_SLEEP = 2'd2;
  localparam ST_WOKE = 2'd3;
  // WOKE lasts one cycle and drops the pending sleep request

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg init_request_q;
  reg sleep_request_q;
  reg wakeup_enable_q;
  reg [7:0] bus_timing_reg_0_q;
  reg [7:0] bus_timing_reg_1_q;
  reg [7:0] acceptance_control_q;
  reg [7:0] acceptance_code_regs_q [0:7];
  reg [7:0] acceptance_mask_regs_q [0:7];
  reg [3:0] idle_cnt_q;
  reg can_rx_q;
  reg [5:0] tq_cnt_q;

  wire init_ack = (state_q == ST_INIT);
  wire sleep_ack = (state_q == ST_SLEEP);
  wire init_active = init_request_q & init_ack;
  wire sleep_active = sleep_request_q & sleep_ack;
  wire bus_edge = (can_rx != can_rx_q);
  wire bus_idle = (idle_cnt_q == `CMH_IDLE_CYCLES);

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  reg aw_held_q;
  reg w_held_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire [7:0] wr_idx = awaddr_q[ADDR_W-1:2] > 8'hFF ? 8'hFF : awaddr_q[9:2];
  wire wr_byte = wstrb_q[0];
  wire [7:0] wr_val = wdata_q[7:0];
  reg wr_known;

  // Address decode for writes
  // Code registers sit at 0x10-0x17, mask registers at 0x18-0x1F
  always @* begin
    wr_known = 1'b0;
    case (wr_idx)
      `CMH_IDX_CTL0, `CMH_IDX_CTL1, `CMH_IDX_BTR0, `CMH_IDX_BTR1, `CMH_IDX_IDAC: wr_known = 1'b1;
      default: wr_known = ((wr_idx & 8'hF8) == `CMH_IDX_IDAR) || ((wr_idx & 8'hF8) == `CMH_IDX_IDMR);
    endcase
  end

  // Capture address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMH_RESP_OKAY;
    end else begin
      // Each ready drops on its own take and while a response waits
      s_axi_awready <= ~aw_held_q & ~aw_take & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_q & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `CMH_RESP_OKAY : `CMH_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Only byte lane 0 carries data; protected registers need init mode
  wire wr_en = wr_go & wr_byte;
  wire prot_ok = wr_en & init_active;

  reg init_request_d;
  reg sleep_request_d;

  // Next request bits, writable anytime; a host write wins over the wakeup clear
  always @* begin
    init_request_d = init_request_q;
    sleep_request_d = sleep_request_q;
    if (wr_en && wr_idx == `CMH_IDX_CTL0) begin
      init_request_d = wr_val[`CMH_CTL0_INIT_REQUEST];
      sleep_request_d = wr_val[`CMH_CTL0_SLEEP_REQUEST];
    end else if (state_q == ST_WOKE) begin
      sleep_request_d = 1'b0; // Wakeup drops the pending sleep request
    end
  end

  // Request bit flops; init request comes up set
  always @(posedge aclk) begin
    if (!aresetn) begin
      init_request_q <= 1'b1;
      sleep_request_q <= 1'b0;
    end else begin
      init_request_q <= init_request_d;
      sleep_request_q <= sleep_request_d;
    end
  end

  // Protected configuration, ignored outside init mode
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_enable_q <= 1'b0;
      bus_timing_reg_0_q <= `CMH_RST_BTR0;
      bus_timing_reg_1_q <= `CMH_RST_BYTE;
      acceptance_control_q <= `CMH_RST_BYTE;
      for (i = 0; i < 8; i = i + 1) begin
        acceptance_code_regs_q[i] <= `CMH_RST_BYTE;
        acceptance_mask_regs_q[i] <= `CMH_RST_BYTE;
      end
    end else if (prot_ok) begin
      case (wr_idx)
        `CMH_IDX_CTL1: wakeup_enable_q <= wr_val[`CMH_CTL1_WAKEUP_ENABLE];
        `CMH_IDX_BTR0: bus_timing_reg_0_q <= wr_val;
        `CMH_IDX_BTR1: bus_timing_reg_1_q <= wr_val;
        `CMH_IDX_IDAC: acceptance_control_q <= wr_val;
        default: begin
          if ((wr_idx & 8'hF8) == `CMH_IDX_IDAR) begin
            acceptance_code_regs_q[wr_idx[2:0]] <= wr_val;
          end
          if ((wr_idx & 8'hF8) == `CMH_IDX_IDMR) begin
            acceptance_mask_regs_q[wr_idx[2:0]] <= wr_val;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode handshake
  // ----------------------------------------------------------------
  // Bus activity watch: any edge resets idle timer
  // Held level starts recessive so reset gives no false edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      can_rx_q <= 1'b1;
      idle_cnt_q <= 4'h0;
    end else begin
      can_rx_q <= can_rx;
      if (bus_edge) begin
        idle_cnt_q <= 4'h0;
      end else if (!bus_idle) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
    end
  end

  // Next mode; init request wins over sleep
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (init_request_q) begin
          state_d = ST_INIT;
        end else if (sleep_request_q && bus_idle) begin
          state_d = ST_SLEEP;
        end
      end
      ST_INIT: begin
        if (!init_request_q) begin
          state_d = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (init_request_q) begin
          state_d = ST_INIT;
        end else if (!sleep_request_q) begin
          state_d = ST_RUN;
        end else if (wakeup_enable_q && bus_edge) begin
          state_d = ST_WOKE;
        end
      end
      ST_WOKE: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  // Mode register
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Time-quantum divider and jump width
  // ----------------------------------------------------------------
  // Field views of bus timing 0
  wire [5:0] tq_prescaler = bus_timing_reg_0_q[`CMH_BRP_HI:`CMH_BRP_LO];
  wire [1:0] sync_jump_width = bus_timing_reg_0_q[`CMH_SJW_HI:`CMH_SJW_LO];

  // Tick every prescaler+1 source cycles; halted in init and sleep.
  // Mode levels and tick follow the next state, so a tick never
  // shares a cycle with a freshly raised init or sleep level.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tq_cnt_q <= 6'h00;
      tq_tick <= 1'b0;
      sjw_tq <= 3'h1;
      init_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end else begin
      init_mode <= (state_d == ST_INIT) & init_request_d;
      sleep_mode <= (state_d == ST_SLEEP) & sleep_request_d;
      sjw_tq <= {1'b0, sync_jump_width} + 3'h1;
      if (state_d != ST_RUN || tq_cnt_q >= tq_prescaler) begin
        tq_cnt_q <= 6'h00;
        tq_tick <= (state_d == ST_RUN);
      end else begin
        tq_cnt_q <= tq_cnt_q + 6'h01;
        tq_tick <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire [7:0] rd_idx = s_axi_araddr[ADDR_W-1:2] > 8'hFF ? 8'hFF : s_axi_araddr[9:2];
  reg [7:0] rd_val;
  reg rd_known;

  // Read mux; all registers readable anytime
  // Status index shows both mode levels and the live quantum count
  always @* begin
    rd_val = 8'h00;
    rd_known = 1'b1;
    case (rd_idx)
      `CMH_IDX_CTL0: rd_val = {6'h00, sleep_request_q, init_request_q};
      `CMH_IDX_CTL1: rd_val = {5'h00, wakeup_enable_q, sleep_ack, init_ack};
      `CMH_IDX_BTR0: rd_val = bus_timing_reg_0_q;
      `CMH_IDX_BTR1: rd_val = bus_timing_reg_1_q;
      `CMH_IDX_IDAC: rd_val = acceptance_control_q;
      `CMH_IDX_TQSTAT: rd_val = {init_active, sleep_active, tq_cnt_q};
      default: begin
        if ((rd_idx & 8'hF8) == `CMH_IDX_IDAR) begin
          rd_val = acceptance_code_regs_q[rd_idx[2:0]];
        end else if ((rd_idx & 8'hF8) == `CMH_IDX_IDMR) begin
          rd_val = acceptance_mask_regs_q[rd_idx[2:0]];
        end else begin
          rd_known = 1'b0;
        end
      end
    endcase
  end

  // Read answer; one read in flight, data stands until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CMH_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_known ? `CMH_RESP_OKAY : `CMH_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> shared/cmh_consts.vh
// Constants for the CAN mode handshake and bit timing block
`ifndef CMH_CONSTS_VH
`define CMH_CONSTS_VH
// Register indices (byte address = 4 * index)
`define CMH_IDX_CTL0 8'h00
`define CMH_IDX_CTL1 8'h01
`define CMH_IDX_BTR0 8'h02
`define CMH_IDX_BTR1 8'h03
`define CMH_IDX_IDAC 8'h0B
`define CMH_IDX_IDAR 8'h10
`define CMH_IDX_IDMR 8'h18
`define CMH_IDX_TQSTAT 8'h30
// Control 0 fields (request bits)
`define CMH_CTL0_INIT_REQUEST 0
`define CMH_CTL0_SLEEP_REQUEST 1
// Control 1 fields
`define CMH_CTL1_INIT_ACK 0
`define CMH_CTL1_SLEEP_ACK 1
`define CMH_CTL1_WAKEUP_ENABLE 2
// Bus timing 0 fields
`define CMH_SJW_HI 7
`define CMH_SJW_LO 6
`define CMH_BRP_HI 5
`define CMH_BRP_LO 0
// Reset values
`define CMH_RST_BTR0 8'h00
`define CMH_RST_CTL1 8'h00
`define CMH_RST_BYTE 8'h00
// Cycles of bus silence before sleep is entered
`define CMH_IDLE_CYCLES 4'hB
// AXI responses
`define CMH_RESP_OKAY 2'b00
`define CMH_RESP_SLVERR 2'b10
`endif

// >>> test/cmh_bus_model.sv
// Far-side bus model driving the receive line
`timescale 1ns/1ps
module cmh_bus_model (
  input wire logic aclk,
  input wire logic wake,
  output logic can_rx
);
  initial can_rx = 1'b1;
  // Idle recessive; a wake pulse sends one short dominant burst
  always @(posedge wake) begin
    @(posedge aclk);
    can_rx <= 1'b0;
    repeat (3) @(posedge aclk);
    can_rx <= 1'b1;
  end
endmodule

// >>> test/cmh_top_chk.sv
// Assertion checker for the CAN mode and bit timing block
`timescale 1ns/1ps
module cmh_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic can_rx,
  input wire logic tq_tick,
  input wire logic [2:0] sjw_tq,
  input wire logic init_mode,
  input wire logic sleep_mode
);
  logic prev_rx_q;
  logic [3:0] quiet_q;
  // Count cycles of a steady bus level
  always @(posedge aclk) begin
    prev_rx_q <= can_rx;
    if (!aresetn || can_rx != prev_rx_q) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_wr_answer;
    ##[1:4] s_axi_bvalid;
  endsequence
  property p_wr_resp; s_wr_taken |-> s_wr_answer; endproperty
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rd_one; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_sjw_range; sjw_tq >= 3'h1 && sjw_tq <= 3'h4; endproperty
  property p_tick_run; tq_tick |-> !init_mode && !sleep_mode; endproperty
  property p_sjw_hold; !init_mode && !$past(init_mode) |-> $stable(sjw_tq); endproperty
  property p_sleep_quiet; $rose(sleep_mode) |-> $past(quiet_q, 2) >= 4'h8; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_busy: assert property (p_busy) else $error("ready while answer pending");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_rd_one: assert property (p_rd_one) else $error("read ready while pending");
  a_sjw_range: assert property (p_sjw_range) else $error("jump width out of range");
  a_tick_run: assert property (p_tick_run) else $error("tick outside run mode");
  a_sjw_hold: assert property (p_sjw_hold) else $error("jump width changed outside init");
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep entered on busy bus");
endmodule
bind cmh_top cmh_top_chk i_cmh_top_chk (.*);

// >>> test/cmh_top_tb.sv
// Self-checking bench for the CAN mode and bit timing block
`timescale 1ns/1ps
`include "cmh_consts.vh"
module cmh_top_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, wake = 1'b0;
  logic [9:0] awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, can_rx, tq_tick, init_mode, sleep_mode;
  logic [2:0] sjw_tq;
  int fail_count = 0, total_checks = 0, n;
  cmh_top i_cmh_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .can_rx(can_rx),
    .tq_tick(tq_tick), .sjw_tq(sjw_tq), .init_mode(init_mode), .sleep_mode(sleep_mode));
  cmh_bus_model i_cmh_bus_model (.aclk(aclk), .wake(wake), .can_rx(can_rx));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!aw_done || !w_done);
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    resp = rresp;
    got = rdata;
    rready <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(sjw_tq, 32'h1);
    rd(10'h008);
    chk(got, 32'h0);
    rd(10'h004);
    chk(got, 32'h1);
    chk(init_mode, 32'h1);
  endtask
  task automatic t_timing;
    for (int k = 0; k < 4; k++) begin
      wr(10'h008, {24'h0, k[1:0], 6'h02});
      repeat (2) @(posedge aclk);
      chk(sjw_tq, k + 1);
    end
    rd(10'h008);
    chk(got, 32'hC2);
    rd(10'h0C0);
    chk(got, 32'h80);
    wr(10'h040, 32'h5A);
    wr(10'h060, 32'hA5);
    rd(10'h040);
    chk(got, 32'h5A);
    rd(10'h060);
    chk(got, 32'hA5);
    wr(10'h004, 32'h4);
    wr(10'h000, 32'h0);
    repeat (3) @(posedge aclk);
    chk(init_mode, 32'h0);
    n = 0;
    while (tq_tick !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (tq_tick !== 1'b1 && n < 200);
    chk(n, 32'h3);
    wr(10'h008, 32'hFF);
    chk(resp, 32'h0);
    rd(10'h008);
    chk(got, 32'hC2);
    wr(10'h004, 32'h0);
    rd(10'h004);
    chk(got, 32'h4);
    wr(10'h040, 32'h11);
    rd(10'h040);
    chk(got, 32'h5A);
  endtask
  task automatic t_unmapped;
    rd(10'h3FC);
    chk(resp, `CMH_RESP_SLVERR);
    chk(got, 32'h0);
    wr(10'h3FC, 32'h5);
    chk(resp, `CMH_RESP_SLVERR);
  endtask
  task automatic t_sleep;
    wr(10'h000, 32'h2);
    n = 0;
    while (sleep_mode !== 1'b1 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    rd(10'h004);
    chk(got, 32'h6);
    chk(sleep_mode, 32'h1);
    rd(10'h0C0);
    chk(got, 32'h40);
    wake <= 1'b1;
    n = 0;
    while (sleep_mode !== 1'b0 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    wake <= 1'b0;
    rd(10'h004);
    chk(got, 32'h4);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Clock
  initial begin
    forever #20 aclk = ~aclk;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_timing;
    t_unmapped;
    t_sleep;
    close_out;
  end
endmodule
